// ==== logic/ofd_ctl.sv ====
// host controller end: register port for software, recovery sequences
// assumes the device end on the same clock through ofd_if
`timescale 1ns/10ps
module ofd_ctl
	import ofd_pkg::*;
#(
	parameter int SETTLE_CYC = OSC_SETTLE_CYC,
	parameter int TRIM_CYC = TRIM_WAIT_CYC
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// device side
	ofd_if.ctl bus,
	// software port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// interrupt
	output logic irq
);

	ofd_state_t st_r;
	ofd_state_t stNxt;
	logic [4:0] tgt_r;
	logic [4:0] busAddr_r;
	logic [4:0] addrNxt;
	logic [7:0] busWdata_r;
	logic [7:0] dataNxt;
	logic [7:0] data_r;
	logic [7:0] stat_r;
	logic [7:0] mask_r;
	logic [7:0] rdOut_r;
	logic [7:0] ev;
	logic busWr_r;
	logic busRd_r;
	logic wrNxt;
	logic rdNxt;
	logic chk_r;
	logic chkNxt;
	logic autoPend_r;
	logic autoGo;
	logic evRead;
	logic evRestart;
	logic irq_r;
	logic [31:0] settleCnt_r;
	logic [31:0] trimCnt_r;

	wire cmdWr = regWr && regAddr == H_CMD;
	wire dataWr = regWr && regAddr == H_DATA;
	wire idle = st_r == ST_IDLE;
	wire settled = settleCnt_r == 32'(SETTLE_CYC);
	wire trimWait = trimCnt_r != '0;
	wire trimStart = idle && dataWr && tgt_r == REG_SQW && regWdata[BIT_OTP];
	wire earlyClr = cmdWr && regWdata[CMD_CLR_OF] && !settled;
	wire trimRead = cmdWr && regWdata[CMD_READ] && tgt_r == REG_TRIM && trimWait;
	wire refused = ((cmdWr || dataWr) && !idle) || (idle && (earlyClr || trimRead));
	wire [7:0] w1c = (regWr && regAddr == H_STAT) ? regWdata : '0;
	wire [7:0] statNxt = (stat_r & ~w1c) | ev;
	wire [7:0] info = {5'h00, trimWait, settled, !idle};
	wire [7:0] rdMux = !regRd ? '0 :
		regAddr == H_TGT ? {3'h0, tgt_r} :
		regAddr == H_DATA ? data_r :
		regAddr == H_STAT ? stat_r :
		regAddr == H_MASK ? mask_r :
		regAddr == H_INFO ? info : '0;

	// sequencer
	always_comb
	begin
		stNxt = st_r;
		wrNxt = 1'b0;
		rdNxt = 1'b0;
		addrNxt = busAddr_r;
		dataNxt = busWdata_r;
		chkNxt = chk_r;
		autoGo = 1'b0;
		evRead = 1'b0;
		evRestart = 1'b0;
		case (st_r)
			ST_IDLE:
			begin
				if (dataWr)
				begin
					wrNxt = 1'b1;
					addrNxt = tgt_r;
					dataNxt = regWdata;
				end
				else if (cmdWr && regWdata[CMD_READ] && !trimRead)
				begin
					rdNxt = 1'b1;
					addrNxt = tgt_r;
					chkNxt = 1'b0;
					stNxt = ST_RD_GAP;
				end
				else if (cmdWr && regWdata[CMD_RESTART])
					stNxt = ST_HALT_HI;
				else if (cmdWr && regWdata[CMD_CLR_OF] && settled)
				begin
					chkNxt = 1'b0;
					stNxt = ST_CLR;
				end
				else if (autoPend_r && settled)
				begin
					autoGo = 1'b1;
					chkNxt = 1'b1;
					stNxt = ST_CLR;
				end
			end
			ST_HALT_HI:
			begin
				wrNxt = 1'b1;
				addrNxt = REG_SEC;
				dataNxt = SEC_HALT_VAL;
				stNxt = ST_HALT_LO;
			end
			ST_HALT_LO:
			begin
				wrNxt = 1'b1;
				addrNxt = REG_SEC;
				dataNxt = RST_ZERO;
				evRestart = 1'b1;
				stNxt = ST_IDLE;
			end
			ST_CLR:
			begin
				wrNxt = 1'b1;
				addrNxt = REG_FLAGS;
				dataNxt = RST_ZERO;
				stNxt = chk_r ? ST_CHK : ST_IDLE;
			end
			ST_CHK:
			begin
				rdNxt = 1'b1;
				addrNxt = REG_FLAGS;
				stNxt = ST_RD_GAP;
			end
			ST_RD_GAP:
				stNxt = ST_RD_CAP;
			ST_RD_CAP:
			begin
				evRead = !chk_r;
				// flag still stuck after settling: restart
				stNxt = (chk_r && bus.rdata[BIT_OF]) ? ST_HALT_HI : ST_IDLE;
			end
			default:
				stNxt = ST_IDLE;
		endcase
		ev = '0;
		ev[STAT_PIN] = ~bus.intLevel;
		ev[STAT_READ] = evRead;
		ev[STAT_REFUSED] = refused;
		ev[STAT_TRIM] = trimCnt_r == 32'd1;
		ev[STAT_RESTART] = evRestart;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= ST_IDLE;
			busAddr_r <= '0;
			busWdata_r <= '0;
			busWr_r <= 1'b0;
			busRd_r <= 1'b0;
			chk_r <= 1'b0;
			autoPend_r <= 1'b1;
			tgt_r <= '0;
			data_r <= '0;
			stat_r <= '0;
			mask_r <= '0;
			rdOut_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			st_r <= stNxt;
			busAddr_r <= addrNxt;
			busWdata_r <= dataNxt;
			busWr_r <= wrNxt;
			busRd_r <= rdNxt;
			chk_r <= chkNxt;
			if (autoGo)
				autoPend_r <= 1'b0;
			if (regWr && regAddr == H_TGT)
				tgt_r <= regWdata[4:0];
			if (regWr && regAddr == H_MASK)
				mask_r <= regWdata;
			if (evRead)
				data_r <= bus.rdata;
			stat_r <= statNxt;
			rdOut_r <= rdMux;
			irq_r <= |(stat_r & mask_r);
		end
	end

	// running time since power-up or restart, and trim wait
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			settleCnt_r <= '0;
			trimCnt_r <= '0;
		end
		else
		begin
			if (evRestart)
				settleCnt_r <= '0;
			else if (!settled)
				settleCnt_r <= settleCnt_r + 32'd1;
			if (trimStart)
				trimCnt_r <= 32'(TRIM_CYC);
			else if (trimWait)
				trimCnt_r <= trimCnt_r - 32'd1;
		end
	end

	assign bus.addr = busAddr_r;
	assign bus.wdata = busWdata_r;
	assign bus.wr = busWr_r;
	assign bus.rd = busRd_r;
	assign regRdata = rdOut_r;
	assign irq = irq_r;

endmodule

// ==== logic/ofd_dev.sv ====
// clock device end: fail flag, power-up defaults, trim load, pin
// assumes sys_rst marks the first power-up and inputs are synchronous
`timescale 1ns/10ps
module ofd_dev
	import ofd_pkg::*;
#(
	parameter int TIMEOUT_CYC = OSC_TIMEOUT_CYC,
	parameter int TRIM_CYC = TRIM_WAIT_CYC
)(
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register port and interrupt pin
	ofd_if.dev bus,
	// crystal and supply status
	input wire logic xtalClk,
	input wire logic supplyLow,
	input wire logic mainOff,
	input wire logic powerRestore,
	// factory trim value
	input wire logic [7:0] otpTrim,
	// analog side
	output logic oscRun,
	output logic [7:0] analogTrim
);

	logic [7:0] mem_r [REG_NUM];
	logic [7:0] memNxt [REG_NUM];
	logic [7:0] rdData_r;
	logic intOeN_r;
	logic intDrv_r;
	logic oscRun_r;
	logic xtalPrev_r;
	logic trimDone_r;
	logic [31:0] idleCnt_r;
	logic [31:0] trimCnt_r;

	// bus is dead while main power is off
	wire wrEn = bus.wr & ~mainOff;
	wire rdEn = bus.rd & ~mainOff;
	wire flagWr = wrEn && bus.addr == REG_FLAGS;
	wire trimWr = wrEn && bus.addr == REG_TRIM;

	// control bits
	wire otpOn = mem_r[REG_SQW][BIT_OTP];
	wire oscHalt = mem_r[REG_SEC][BIT_ST];
	wire osc_fail_irq_en = mem_r[REG_ALM1][BIT_OSC_FAIL_IRQ_EN];
	wire alarm_one_irq_en = mem_r[REG_ALM1][BIT_ALARM_ONE_IRQ_EN];
	wire wdogOn = mem_r[REG_WDOG] != RST_ZERO;
	wire ofFlag = mem_r[REG_FLAGS][BIT_OF];
	wire outLevel = mem_r[REG_CAL][BIT_OUT];

	// oscillator watch
	wire xtalEdge = xtalClk ^ xtalPrev_r;
	wire oscStopped = idleCnt_r == 32'(TIMEOUT_CYC);
	wire ofSet = oscStopped | oscHalt | supplyLow;
	// only a written zero drops the flag
	wire ofHeld = ofFlag & ~(flagWr & ~bus.wdata[BIT_OF]);

	// factory trim transfer
	wire trimAtEnd = trimCnt_r == 32'(TRIM_CYC);
	wire trimLoad = otpOn & ~trimDone_r & trimAtEnd;
	wire trimLock = trimWr & otpOn;

	// interrupt pin
	wire irqMode = osc_fail_irq_en | alarm_one_irq_en | wdogOn;
	wire ofIrq = osc_fail_irq_en & ofFlag;
	wire pinLow = irqMode ? ofIrq : ~outLevel;

	// next register contents
	always_comb
	begin
		for (int i = 0; i < REG_NUM; i++)
			memNxt[i] = mem_r[i];
		if (wrEn && !trimLock)
			memNxt[bus.addr] = bus.wdata;
		if (powerRestore)
		begin
			// later power-up on battery
			memNxt[REG_CAL][BIT_FT] = 1'b0;
			memNxt[REG_WDOG] = PWR_WDOG_VAL;
			memNxt[REG_TMR][BIT_TE] = 1'b0;
			memNxt[REG_STAMP][BIT_HT] = 1'b1;
		end
		if (trimLoad)
			memNxt[REG_TRIM] = otpTrim;
		// set wins over a clearing write; works with bus dead too
		memNxt[REG_FLAGS][BIT_OF] = ofSet | ofHeld;
	end

	// register file
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < REG_NUM; i++)
				mem_r[i] <= rstVal(5'(i));
		end
		else
		begin
			for (int i = 0; i < REG_NUM; i++)
				mem_r[i] <= memNxt[i];
		end
	end

	// crystal edge timeout
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			xtalPrev_r <= 1'b0;
			idleCnt_r <= '0;
		end
		else
		begin
			xtalPrev_r <= xtalClk;
			if (xtalEdge)
				idleCnt_r <= '0;
			else if (!oscStopped)
				idleCnt_r <= idleCnt_r + 32'd1;
		end
	end

	// trim read delay
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trimCnt_r <= '0;
			trimDone_r <= 1'b0;
		end
		else if (!otpOn)
		begin
			trimCnt_r <= '0;
			trimDone_r <= 1'b0;
		end
		else
		begin
			if (!trimDone_r && !trimAtEnd)
				trimCnt_r <= trimCnt_r + 32'd1;
			if (trimLoad)
				trimDone_r <= 1'b1;
		end
	end

	// read data, pin and oscillator enable
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rdData_r <= '0;
			intOeN_r <= 1'b1;
			intDrv_r <= 1'b0;
			oscRun_r <= 1'b1;
		end
		else
		begin
			// reading never touches the flag
			rdData_r <= rdEn ? mem_r[bus.addr] : '0;
			intOeN_r <= ~pinLow;
			intDrv_r <= 1'b0;
			oscRun_r <= ~oscHalt;
		end
	end

	assign bus.rdata = rdData_r;
	assign bus.intDrv = intDrv_r;
	assign bus.intOeN = intOeN_r;
	assign oscRun = oscRun_r;
	assign analogTrim = mem_r[REG_TRIM];

endmodule

// ==== logic/ofd_if.sv ====
// register port and open-drain interrupt pin between the two ends
// assumes an external pull-up on the interrupt line
`timescale 1ns/10ps
interface ofd_if;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic intDrv;
	logic intOeN;
	wire intLevel;

	// pull-up when released
	assign intLevel = intOeN ? 1'b1 : intDrv;

	modport dev (input addr, input wdata, input wr, input rd,
		output rdata, output intDrv, output intOeN);
	modport ctl (output addr, output wdata, output wr, output rd,
		input rdata, input intLevel);
endinterface

// ==== logic/ofd_pkg.sv ====
// constants, register map, states and timing shared by both ends
// assumes one 125 MHz clock and one power-on reset for both ends
// Summary of operation
// - stopped oscillator sets the fail flag
// - fail flag reads one after first power-up
// - halt bit or low supply sets flag
// - host restarts oscillator by pulsing halt bit
// - flag stuck after 4 s: pulse halt
// - only writing zero clears the fail flag
// - host clear command refused before 4 s running; a data write of zero clears at once
// - stop events recorded during main power loss
// - enabled fail flag pulls interrupt pin low
// - pin released by clearing enable or flag
// - first power-up defaults, part one
// - first power-up defaults, part two
// - later power-up clears some bits, sets stamp
// - trim-load copies factory trim, register read-only
// - trim-load zero: trim register freely writable
// - host waits 9 ms after trim-load
// - no interrupt enabled: pin follows output level
package ofd_pkg;
	// clock and times
	localparam int CLK_HZ = 125000000;
	localparam int OSC_SETTLE_S = 4;
	localparam int OSC_SETTLE_CYC = OSC_SETTLE_S * CLK_HZ;
	localparam int TRIM_WAIT_MS = 9;
	localparam int TRIM_WAIT_CYC = TRIM_WAIT_MS * (CLK_HZ / 1000);
	localparam int OSC_TIMEOUT_CYC = 8192;
	// device register map
	localparam int REG_NUM = 32;
	localparam logic [4:0] REG_SEC = 5'h01;
	localparam logic [4:0] REG_HOUR = 5'h03;
	localparam logic [4:0] REG_CAL = 5'h08;
	localparam logic [4:0] REG_WDOG = 5'h09;
	localparam logic [4:0] REG_ALM1 = 5'h0A;
	localparam logic [4:0] REG_ALM1_RPT = 5'h0B;
	localparam logic [4:0] REG_STAMP = 5'h0C;
	localparam logic [4:0] REG_FLAGS = 5'h0F;
	localparam logic [4:0] REG_TMR = 5'h10;
	localparam logic [4:0] REG_TRIM = 5'h12;
	localparam logic [4:0] REG_SQW = 5'h13;
	localparam logic [4:0] REG_ALM2 = 5'h14;
	// device bit positions
	localparam int BIT_ST = 7;
	localparam int BIT_OUT = 7;
	localparam int BIT_FT = 6;
	localparam int BIT_OSC_FAIL_IRQ_EN = 7;
	localparam int BIT_ALARM_ONE_IRQ_EN = 6;
	localparam int BIT_HT = 6;
	localparam int BIT_OF = 2;
	localparam int BIT_TE = 7;
	localparam int BIT_OTP = 3;
	// power-on values and halt pulse value
	localparam logic [7:0] RST_CAL = 8'h80;
	localparam logic [7:0] RST_ALM1 = 8'h10;
	localparam logic [7:0] RST_STAMP = 8'h40;
	localparam logic [7:0] RST_FLAGS = 8'h04;
	localparam logic [7:0] RST_TMR = 8'h03;
	localparam logic [7:0] RST_SQW = 8'h10;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] PWR_WDOG_VAL = 8'h00;
	localparam logic [7:0] SEC_HALT_VAL = 8'h80;
	// controller register map
	localparam logic [2:0] H_TGT = 3'h0;
	localparam logic [2:0] H_DATA = 3'h1;
	localparam logic [2:0] H_CMD = 3'h2;
	localparam logic [2:0] H_STAT = 3'h3;
	localparam logic [2:0] H_MASK = 3'h4;
	localparam logic [2:0] H_INFO = 3'h5;
	localparam int CMD_READ = 0;
	localparam int CMD_RESTART = 1;
	localparam int CMD_CLR_OF = 2;
	localparam int STAT_PIN = 0;
	localparam int STAT_READ = 1;
	localparam int STAT_REFUSED = 2;
	localparam int STAT_TRIM = 3;
	localparam int STAT_RESTART = 4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HALT_HI = 3'b001,
		ST_HALT_LO = 3'b010,
		ST_CLR = 3'b011,
		ST_CHK = 3'b100,
		ST_RD_GAP = 3'b101,
		ST_RD_CAP = 3'b110
	} ofd_state_t;

	// first power-up contents per register
	function automatic logic [7:0] rstVal(input logic [4:0] a);
		case (a)
			REG_CAL: rstVal = RST_CAL;
			REG_ALM1: rstVal = RST_ALM1;
			REG_STAMP: rstVal = RST_STAMP;
			REG_FLAGS: rstVal = RST_FLAGS;
			REG_TMR: rstVal = RST_TMR;
			REG_SQW: rstVal = RST_SQW;
			default: rstVal = RST_ZERO;
		endcase
	endfunction
endpackage

// ==== tb/ofd_asserts.sv ====
// checker on the device port and the interrupt line
// assumes instantiation beside the interface, one clock domain
`timescale 1ns/10ps
module ofd_asserts
	import ofd_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// device port
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// interrupt pin
	input wire logic intDrv,
	input wire logic intOeN,
	input wire logic intLevel
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	a_strobes_apart: assert property (!(wr && rd))
		else $error("read and write strobes together");
	a_read_single: assert property (rd |=> !rd)
		else $error("device read strobe too long");
	a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside answer cycle");
	a_pin_low: assert property (!intOeN |-> !intDrv && !intLevel)
		else $error("enabled pin not low");
	a_release_cause: assert property ($rose(intOeN) |-> $past(wr, 2) || $past(wr, 3))
		else $error("pin released without a write");
	a_read_keeps: assert property (
		rd && !intOeN && !$past(wr) && !$past(wr, 2) |=> !intOeN)
		else $error("read released the pin");
	a_halt_pulse: assert property (
		wr && addr == REG_SEC && wdata == SEC_HALT_VAL |=> wr && addr == REG_SEC && wdata == 8'h00)
		else $error("halt not pulsed back low");
	a_settle_gap: assert property (
		wr && addr == REG_SEC && wdata == 8'h00 |=> !(wr && addr == REG_FLAGS) [*8])
		else $error("fail flag cleared too early");
endmodule

// ==== tb/test_oscillator_fail_and_defaults.sv ====
// bench: controller and device ends joined by the interface
// assumes package, interface and both ends compiled before it
`timescale 1ns/10ps
module test_oscillator_fail_and_defaults
	import ofd_pkg::*;
;
	localparam int TMO = 16;
	localparam int TRW = 20;
	localparam int STL = 400;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic irq;
	logic xtalClk = 1'b0;
	logic xtalOn = 1'b1;
	logic supplyLow = 1'b0;
	logic mainOff = 1'b0;
	logic powerRestore = 1'b0;
	logic [7:0] otpTrim = 8'hC3;
	logic oscRun;
	logic [7:0] analogTrim;
	logic [7:0] v;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [4:0] dA [12] = '{REG_FLAGS, REG_CAL, REG_ALM1, REG_STAMP, REG_TMR, REG_SQW,
		REG_SEC, REG_HOUR, REG_WDOG, REG_TRIM, REG_ALM2, REG_ALM1_RPT};
	logic [7:0] dV [12] = '{8'h04, 8'h80, 8'h10, 8'h40, 8'h03, 8'h10,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	ofd_if link ();
	ofd_dev #(.TIMEOUT_CYC(TMO), .TRIM_CYC(TRW)) ofd_dev_inst (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .bus(link), .xtalClk(xtalClk), .supplyLow(supplyLow),
		.mainOff(mainOff), .powerRestore(powerRestore), .otpTrim(otpTrim),
		.oscRun(oscRun), .analogTrim(analogTrim));
	ofd_ctl #(.SETTLE_CYC(STL), .TRIM_CYC(TRW)) ofd_ctl_inst (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .bus(link), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
	ofd_asserts ofd_asserts_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
		.intDrv(link.intDrv), .intOeN(link.intOeN), .intLevel(link.intLevel));
	initial
	begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic give_verdict();
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (xtalOn && cyc % 4 == 0)
			xtalClk <= ~xtalClk;
		if (cyc == 20000)
		begin
			fails++;
			give_verdict();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic swr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic srd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic devWr(input logic [4:0] a, input logic [7:0] d);
		swr(H_TGT, {3'h0, a});
		swr(H_DATA, d);
		waitc(5);
	endtask
	task automatic devChk(input logic [4:0] a, input logic [7:0] e);
		int n;
		logic [7:0] d;
		swr(H_TGT, {3'h0, a});
		swr(H_CMD, 8'h01);
		n = 0;
		d = 8'h00;
		while (!d[STAT_READ] && n < 20)
		begin
			srd(H_STAT, d);
			n++;
		end
		swr(H_STAT, 8'h02);
		srd(H_DATA, d);
		check(d, e);
	endtask
	task automatic stopXtal(input int n);
		@(posedge sys_clk);
		xtalOn <= 1'b0;
		repeat (n) @(posedge sys_clk);
		xtalOn <= 1'b1;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 12; i++)
			devChk(dA[i], dV[i]);
		check({7'h00, link.intLevel}, 8'h01);
		check({7'h00, oscRun}, 8'h01);
		waitc(STL + 100);
		devChk(REG_FLAGS, 8'h00);
		stopXtal(TMO - 8);
		devChk(REG_FLAGS, 8'h00);
		stopXtal(TMO + 8);
		devChk(REG_FLAGS, 8'h04);
		devChk(REG_FLAGS, 8'h04);
		devWr(REG_FLAGS, 8'h00);
		devChk(REG_FLAGS, 8'h00);
		devWr(REG_FLAGS, 8'h04);
		devChk(REG_FLAGS, 8'h00);
		@(posedge sys_clk);
		supplyLow <= 1'b1;
		repeat (3) @(posedge sys_clk);
		supplyLow <= 1'b0;
		devChk(REG_FLAGS, 8'h04);
		devWr(REG_FLAGS, 8'h00);
		@(posedge sys_clk);
		mainOff <= 1'b1;
		stopXtal(TMO + 8);
		mainOff <= 1'b0;
		devChk(REG_FLAGS, 8'h04);
		devWr(REG_FLAGS, 8'h00);
		devWr(REG_ALM1, 8'h80);
		check({7'h00, link.intLevel}, 8'h01);
		swr(H_CMD, 8'h02);
		waitc(8);
		srd(H_STAT, v);
		check(v & 8'h10, 8'h10);
		check({7'h00, link.intLevel}, 8'h00);
		check({7'h00, oscRun}, 8'h01);
		devChk(REG_FLAGS, 8'h04);
		check({7'h00, link.intLevel}, 8'h00);
		devWr(REG_FLAGS, 8'h00);
		check({7'h00, link.intLevel}, 8'h01);
		swr(H_MASK, 8'h01);
		waitc(2);
		check({7'h00, irq}, 8'h01);
		swr(H_STAT, 8'h01);
		waitc(2);
		check({7'h00, irq}, 8'h00);
		devWr(REG_ALM1, 8'h00);
		devWr(REG_CAL, 8'h00);
		check({7'h00, link.intLevel}, 8'h00);
		check({7'h00, irq}, 8'h01);
		swr(H_MASK, 8'h00);
		waitc(2);
		check({7'h00, irq}, 8'h00);
		devWr(REG_CAL, 8'h80);
		check({7'h00, link.intLevel}, 8'h01);
		swr(H_STAT, 8'h01);
		devWr(REG_TRIM, 8'h5A);
		devChk(REG_TRIM, 8'h5A);
		check(analogTrim, 8'h5A);
		devWr(REG_SQW, 8'h18);
		waitc(TRW + 8);
		check(analogTrim, 8'hC3);
		devWr(REG_TRIM, 8'h11);
		devChk(REG_TRIM, 8'hC3);
		devWr(REG_SQW, 8'h10);
		devWr(REG_TRIM, 8'h22);
		devChk(REG_TRIM, 8'h22);
		devWr(REG_CAL, 8'hC0);
		devWr(REG_WDOG, 8'h05);
		devWr(REG_TMR, 8'h83);
		devWr(REG_STAMP, 8'h00);
		@(posedge sys_clk);
		powerRestore <= 1'b1;
		@(posedge sys_clk);
		powerRestore <= 1'b0;
		devChk(REG_CAL, 8'h80);
		devChk(REG_WDOG, 8'h00);
		devChk(REG_TMR, 8'h03);
		devChk(REG_STAMP, 8'h40);
		devChk(REG_TRIM, 8'h22);
		give_verdict();
	end
endmodule
